// [hdl/cam_map_pkg.sv]
// Constants, register map and carrier types for the camera input bit mapper.
// Assumes one system clock domain; every camera pin is asynchronous to it.
package cam_map_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [11:0] OFF_CTRL     = 12'h000;
    localparam logic [11:0] OFF_EXPO     = 12'h004;
    localparam logic [11:0] OFF_GPIO_OUT = 12'h008;
    localparam logic [11:0] OFF_GPIO_IN  = 12'h00C;
    localparam logic [11:0] OFF_AUX      = 12'h010;
    localparam logic [11:0] OFF_STATUS   = 12'h014;

    // Control register field positions.
    localparam int CTRL_WIDE     = 0;
    localparam int CTRL_FMT_LO   = 1;
    localparam int CTRL_GPA_OUT  = 3;
    localparam int CTRL_GPB_OUT  = 4;
    localparam int CTRL_SER_DIFF = 5;
    localparam int CTRL_DIFF_B   = 6;
    localparam int CTRL_DE_FIELD = 7;
    localparam int CTRL_TRIG_A   = 8;
    localparam int CTRL_TRIG_B   = 9;
    localparam int CTRL_W        = 10;

    // Exposure register field positions.
    localparam int EXPO_SYNC_A  = 0;
    localparam int EXPO_SYNC_B  = 1;
    localparam int EXPO_RESET_A = 2;
    localparam int EXPO_RESET_B = 3;
    localparam int EXPO_W       = 4;

    // Status register field positions.
    localparam int STAT_VALID_LO = 0;
    localparam int STAT_OVF_LO   = 2;
    localparam int STAT_FE_LO    = 4;

    // Pixel formats held in the control register.
    localparam logic [1:0] FMT_MONO = 2'h0;
    localparam logic [1:0] FMT_RGB  = 2'h1;
    localparam logic [1:0] FMT_TAP8 = 2'h2;
    localparam logic [1:0] FMT_TAPW = 2'h3;

    // Values after reset.
    localparam logic [CTRL_W-1:0] CTRL_RST     = 10'h000;
    localparam logic [EXPO_W-1:0] EXPO_RST     = 4'h0;
    localparam logic [15:0]       GPIO_OUT_RST = 16'h0000;
    localparam logic [31:0]       RDATA_RST    = 32'h0000_0000;

    // Depth of the two-entry pixel buffer per channel.
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    typedef struct packed {
        logic frame_enable_input;
        logic line_enable_input;
        logic data_enable_input;
        logic camera_clock_input;
    } cam_ctrl_type;

    typedef struct packed {
        logic        frame_enable;
        logic        line_enable;
        logic        data_enable;
        logic [15:0] field0;
        logic [15:0] field1;
        logic [15:0] field2;
        logic [35:0] raw;
    } pix_word_type;

endpackage : cam_map_pkg

// [hdl/camera_input_bit_mapper.sv]
// Camera input bit mapper: pin sampling, bit placement, buffering and APB registers.
// Assumes camera pins are asynchronous to clk_sys and the camera clock is far slower.
//
// Chosen here: the APB slave port and the placing of the registers.

// Functional notes
// - Each GPIO byte port wholly input or output.
// - Channel A MSB-0..15, channel B MSB-16..31.
// - Control inputs: frame, line, data enable, clock.
// - Wide mode: B controls are MSB-32..35.
// - RGB: red 0..11, green 12..23, blue 24..35.
// - Adjacent two-tap 8-bit: odd 0..7, even 8..15.
// - Other two-tap: odd 0..15, even 16..31.
// - Bits count downward from the MSB input.
// - Control outputs carry exposure sync and reset.
// - Single-ended serial uses own receive/transmit pairs.
// - Differential serial spreads one channel over pairs.
// - Two 2-bit aux ports: status, trigger, encoder.
module camera_input_bit_mapper (
    input  wire logic                           clk_sys,
    input  wire logic                           nrst,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [11:0]                    paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [31:0]                    cam_data,
    input  wire cam_map_pkg::cam_ctrl_type      ctrl_a,
    input  wire cam_map_pkg::cam_ctrl_type      ctrl_b,
    output cam_map_pkg::pix_word_type [1:0]     pix_word,
    output logic      [1:0]                     pix_valid,
    input  wire logic [1:0]                     pix_ready,
    output logic                                cam_ctrl_out_a_first,
    output logic                                cam_ctrl_out_a_second,
    output logic                                cam_ctrl_out_b_first,
    output logic                                cam_ctrl_out_b_second,
    input  wire logic [1:0]                     serial_in_pair_first,
    input  wire logic [1:0]                     serial_in_pair_second,
    output logic      [1:0]                     serial_out_pair_first,
    output logic      [1:0]                     serial_out_pair_second,
    input  wire logic [1:0]                     uart_tx,
    input  wire logic [1:0]                     uart_rts,
    output logic      [1:0]                     uart_rx,
    output logic      [1:0]                     uart_cts,
    input  wire logic [3:0]                     aux_in,
    output logic      [3:0]                     aux_level,
    output logic      [1:0]                     aux_trigger,
    input  wire logic [15:0]                    gpio_in,
    output logic      [15:0]                    gpio_out,
    output logic      [15:0]                    gpio_oe_n
);
    import cam_map_pkg::*;

    logic [39:0]        raw_s1_q;
    logic [39:0]        raw_s2_q;
    logic [1:0]         clk_prev_q;
    logic [23:0]        misc_s1_q;
    logic [23:0]        misc_s2_q;
    logic [1:0]         aux_prev_q;
    logic [CTRL_W-1:0]  ctrl_q;
    logic [EXPO_W-1:0]  expo_q;
    logic [15:0]        gpio_out_q;
    logic [15:0]        gpio_oe_n_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic [31:0]        rdata_d;
    logic               addr_ok;
    logic               apb_done;
    logic               apb_wr;
    logic [1:0]         ovf_clr;
    logic [1:0]         ovf;
    logic [1:0]         uart_rx_q;
    logic [1:0]         uart_cts_q;
    logic [1:0]         ser_out1_q;
    logic [1:0]         ser_out2_q;
    logic [1:0]         aux_trig_q;
    logic [35:0]        wide_word;
    logic [1:0]         fmt;

    assign fmt       = ctrl_q[CTRL_FMT_LO+1:CTRL_FMT_LO];
    assign wide_word = {raw_s2_q[39:8], raw_s2_q[3:0]};

    // Two flip-flops on every camera pin before any logic reads it.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            raw_s1_q   <= '0;
            raw_s2_q   <= '0;
            clk_prev_q <= '0;
        end else begin
            raw_s1_q   <= {cam_data, ctrl_a, ctrl_b};
            raw_s2_q   <= raw_s1_q;
            clk_prev_q <= {raw_s2_q[0], raw_s2_q[4]};
        end
    end

    // Two flip-flops on the GPIO, aux and serial input pins.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            misc_s1_q <= '0;
            misc_s2_q <= '0;
        end else begin
            misc_s1_q <= {gpio_in, aux_in, serial_in_pair_first, serial_in_pair_second};
            misc_s2_q <= misc_s1_q;
        end
    end

    // Places the bits of one captured word: channel A by the pixel format, channel B always from MSB-16..31.
    function automatic pix_word_type map_word(input logic [35:0] w,
                                              input cam_ctrl_type c,
                                              input logic [1:0] f,
                                              input logic chb);
        pix_word_type r;
        r              = '0;
        r.frame_enable = c.frame_enable_input;
        r.line_enable  = c.line_enable_input;
        r.data_enable  = c.data_enable_input;
        r.raw          = w;
        if (chb) begin
            r.field0 = w[19:4];
        end else begin
            case (f)
                FMT_RGB: begin
                    r.field0 = {4'h0, w[35:24]};
                    r.field1 = {4'h0, w[23:12]};
                    r.field2 = {4'h0, w[11:0]};
                end
                FMT_TAP8: begin
                    r.field0 = {8'h00, w[35:28]};
                    r.field1 = {8'h00, w[27:20]};
                end
                FMT_TAPW: begin
                    r.field0 = w[35:20];
                    r.field1 = w[19:4];
                end
                default: begin
                    r.field0 = w[35:20];
                end
            endcase
        end
        return r;
    endfunction : map_word

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            cam_ctrl_type c;
            pix_word_type nw;
            pix_word_type head_q;
            pix_word_type tail_q;
            logic [1:0]   cnt_q;
            logic         valid_q;
            logic         ovf_q;
            logic         en;
            logic         rise;
            logic         push;
            logic         pop;
            logic         full;

            assign c    = raw_s2_q[7-4*ch -: 4];
            assign en   = (ch == 0) ? 1'b1 : !ctrl_q[CTRL_WIDE];
            assign rise = c.camera_clock_input && !clk_prev_q[ch];
            assign push = rise && en && c.line_enable_input &&
                          (c.data_enable_input || ctrl_q[CTRL_DE_FIELD]);
            assign pop  = valid_q && pix_ready[ch];
            assign full = (cnt_q == BUF_DEPTH);
            assign nw   = map_word(wide_word, c, fmt, ch == 1);

            // Two-entry buffer; the head register drives the output directly.
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    head_q  <= '0;
                    tail_q  <= '0;
                    cnt_q   <= 2'h0;
                    valid_q <= 1'b0;
                end else begin
                    if (push && pop) begin
                        if (cnt_q == 2'h1) begin
                            head_q <= nw;
                        end else begin
                            head_q <= tail_q;
                            tail_q <= nw;
                        end
                    end else if (push && !full) begin
                        if (cnt_q == 2'h0) begin
                            head_q  <= nw;
                            valid_q <= 1'b1;
                        end else begin
                            tail_q <= nw;
                        end
                        cnt_q <= cnt_q + 2'h1;
                    end else if (pop) begin
                        head_q  <= tail_q;
                        cnt_q   <= cnt_q - 2'h1;
                        valid_q <= (cnt_q == BUF_DEPTH);
                    end
                end
            end

            // Sticky overflow when a word arrives at a full buffer and no word pops in that cycle; setting beats clearing.
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    ovf_q <= 1'b0;
                end else if (push && full && !pop) begin
                    ovf_q <= 1'b1;
                end else if (ovf_clr[ch]) begin
                    ovf_q <= 1'b0;
                end
            end

            assign pix_word[ch]  = head_q;
            assign pix_valid[ch] = valid_q;
            assign ovf[ch]       = ovf_q;
        end
    endgenerate

    // APB slave: one wait state; read data registered as pready rises, write taken on the following edge.
    assign apb_done = psel && penable && pready_q;
    assign apb_wr   = apb_done && pwrite;
    assign ovf_clr  = (apb_wr && paddr == OFF_STATUS) ?
                      pwdata[STAT_OVF_LO+1:STAT_OVF_LO] : 2'h0;

    always_comb begin
        rdata_d = '0;
        addr_ok = 1'b1;
        if (paddr == OFF_CTRL) begin
            rdata_d[CTRL_W-1:0] = ctrl_q;
        end else if (paddr == OFF_EXPO) begin
            rdata_d[EXPO_W-1:0] = expo_q;
        end else if (paddr == OFF_GPIO_OUT) begin
            rdata_d[15:0] = gpio_out_q;
        end else if (paddr == OFF_GPIO_IN) begin
            rdata_d[15:0] = misc_s2_q[23:8];
        end else if (paddr == OFF_AUX) begin
            rdata_d[3:0] = misc_s2_q[7:4];
        end else if (paddr == OFF_STATUS) begin
            rdata_d[STAT_VALID_LO+1:STAT_VALID_LO] = pix_valid;
            rdata_d[STAT_OVF_LO+1:STAT_OVF_LO]     = ovf;
            rdata_d[STAT_FE_LO+1:STAT_FE_LO]       = {raw_s2_q[3], raw_s2_q[7]};
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= RDATA_RST;
        end else if (psel && penable && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= !addr_ok;
            prdata_q  <= pwrite ? RDATA_RST : rdata_d;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Software-written registers.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_q     <= CTRL_RST;
            expo_q     <= EXPO_RST;
            gpio_out_q <= GPIO_OUT_RST;
        end else if (apb_wr) begin
            if (paddr == OFF_CTRL) begin
                ctrl_q <= pwdata[CTRL_W-1:0];
            end else if (paddr == OFF_EXPO) begin
                expo_q <= pwdata[EXPO_W-1:0];
            end else if (paddr == OFF_GPIO_OUT) begin
                gpio_out_q <= pwdata[15:0];
            end
        end
    end

    // Each GPIO byte turns around as a whole.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gpio_oe_n_q <= 16'hFFFF;
        end else begin
            gpio_oe_n_q <= {{8{!ctrl_q[CTRL_GPB_OUT]}}, {8{!ctrl_q[CTRL_GPA_OUT]}}};
        end
    end

    // Serial line routing between the UART and the camera pairs.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            uart_rx_q  <= 2'h3;
            uart_cts_q <= 2'h3;
            ser_out1_q <= 2'h2;
            ser_out2_q <= 2'h2;
        end else if (ctrl_q[CTRL_SER_DIFF]) begin
            uart_rx_q  <= ctrl_q[CTRL_DIFF_B] ? {misc_s2_q[3], 1'b1} : {1'b1, misc_s2_q[3]};
            uart_cts_q <= ctrl_q[CTRL_DIFF_B] ? {misc_s2_q[1], 1'b1} : {1'b1, misc_s2_q[1]};
            if (ctrl_q[CTRL_DIFF_B]) begin
                ser_out1_q <= {uart_tx[1], !uart_tx[1]};
                ser_out2_q <= {uart_rts[1], !uart_rts[1]};
            end else begin
                ser_out1_q <= {uart_tx[0], !uart_tx[0]};
                ser_out2_q <= {uart_rts[0], !uart_rts[0]};
            end
        end else begin
            uart_rx_q  <= {misc_s2_q[1], misc_s2_q[3]};
            uart_cts_q <= {misc_s2_q[0], misc_s2_q[2]};
            ser_out1_q <= {uart_tx[0], uart_rts[0]};
            ser_out2_q <= {uart_tx[1], uart_rts[1]};
        end
    end

    // Aux ports: levels for status or encoder, rising edge of bit 0 as a trigger.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            aux_prev_q <= 2'h0;
            aux_trig_q <= 2'h0;
        end else begin
            aux_prev_q <= {misc_s2_q[6], misc_s2_q[4]};
            aux_trig_q <= {ctrl_q[CTRL_TRIG_B] && misc_s2_q[6] && !aux_prev_q[1],
                           ctrl_q[CTRL_TRIG_A] && misc_s2_q[4] && !aux_prev_q[0]};
        end
    end

    assign prdata                 = prdata_q;
    assign pready                 = pready_q;
    assign pslverr                = pslverr_q;
    assign cam_ctrl_out_a_first   = expo_q[EXPO_SYNC_A];
    assign cam_ctrl_out_b_first   = expo_q[EXPO_SYNC_B];
    assign cam_ctrl_out_a_second  = expo_q[EXPO_RESET_A];
    assign cam_ctrl_out_b_second  = expo_q[EXPO_RESET_B];
    assign serial_out_pair_first  = ser_out1_q;
    assign serial_out_pair_second = ser_out2_q;
    assign uart_rx                = uart_rx_q;
    assign uart_cts               = uart_cts_q;
    assign aux_level              = misc_s2_q[7:4];
    assign aux_trigger            = aux_trig_q;
    assign gpio_out               = gpio_out_q;
    assign gpio_oe_n              = gpio_oe_n_q;

endmodule : camera_input_bit_mapper

// [verif/cam_model.sv]
// Camera stand-in that drives the data pins and both control groups.
// Assumes the bench calls pixel(); the camera clock stands still outside it.
module cam_model (
    output logic [31:0]               cam_data,
    output cam_map_pkg::cam_ctrl_type ctrl_a,
    output cam_map_pkg::cam_ctrl_type ctrl_b
);
    timeunit 1ns;
    timeprecision 100ps;
    import cam_map_pkg::*;

    initial begin
        cam_data = 32'h0000_0000;
        ctrl_a = 4'h0;
        ctrl_b = 4'h0;
    end

    // One pixel at a 187.5 ns period; released lines show the inverse of the last value.
    task automatic pixel(input logic [35:0] w, input logic wide);
        cam_data = w[35:4];
        ctrl_a = 4'b1110;
        ctrl_b = wide ? w[3:0] : 4'b1110;
        #62.5;
        ctrl_a[0] = 1'b1;
        ctrl_b[0] = wide ? w[0] : 1'b1;
        #62.5;
        ctrl_a = 4'h0;
        ctrl_b = wide ? ~w[3:0] : 4'h0;
        cam_data = ~w[35:4];
        #62.5;
    endtask : pixel
endmodule : cam_model

// [verif/camera_input_bit_mapper_chk.sv]
// Port-level assertions for the camera input bit mapper.
// Assumes the register map and latencies fixed by the designer.
module camera_input_bit_mapper_chk (
    input wire logic                            clk_sys,
    input wire logic                            nrst,
    input wire logic                            psel,
    input wire logic                            penable,
    input wire logic                            pwrite,
    input wire logic                            pready,
    input wire logic [11:0]                     paddr,
    input wire logic [31:0]                     pwdata,
    input wire cam_map_pkg::pix_word_type [1:0] pix_word,
    input wire logic [1:0]                      pix_valid,
    input wire logic [1:0]                      pix_ready,
    input wire logic                            cam_ctrl_out_a_first,
    input wire logic                            cam_ctrl_out_a_second,
    input wire logic                            cam_ctrl_out_b_first,
    input wire logic                            cam_ctrl_out_b_second,
    input wire logic [1:0]                      serial_out_pair_first,
    input wire logic [1:0]                      serial_out_pair_second,
    input wire logic [1:0]                      uart_tx,
    input wire logic [1:0]                      uart_rts,
    input wire logic [3:0]                      aux_in,
    input wire logic [3:0]                      aux_level,
    input wire logic [15:0]                     gpio_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    import cam_map_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic [CTRL_W-1:0] ctrl_q;
    logic              wr_ok;
    logic              tx_sel;
    logic              rts_sel;
    logic [1:0]        fmt;
    assign wr_ok = psel && penable && pready && pwrite;
    assign tx_sel = uart_tx[ctrl_q[CTRL_DIFF_B]];
    assign rts_sel = uart_rts[ctrl_q[CTRL_DIFF_B]];
    assign fmt = ctrl_q[CTRL_FMT_LO+1:CTRL_FMT_LO];

    // Mirror of the control register.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ok && paddr == OFF_CTRL) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
        end
    end

    chk_gpio_whole: assert property (gpio_oe_n ==
        {{8{!$past(ctrl_q[CTRL_GPB_OUT])}}, {8{!$past(ctrl_q[CTRL_GPA_OUT])}}})
        else $error("gpio dir");
    chk_expo_outs: assert property (wr_ok && paddr == OFF_EXPO |=>
        {cam_ctrl_out_b_second, cam_ctrl_out_a_second, cam_ctrl_out_b_first,
         cam_ctrl_out_a_first} == $past(pwdata[3:0]))
        else $error("expo outs");
    chk_serial_single: assert property ($past(nrst) && !$past(ctrl_q[CTRL_SER_DIFF]) |->
        serial_out_pair_first == {$past(uart_tx[0]), $past(uart_rts[0])} &&
        serial_out_pair_second == {$past(uart_tx[1]), $past(uart_rts[1])})
        else $error("serial single");
    chk_serial_diff: assert property ($past(nrst) && $past(ctrl_q[CTRL_SER_DIFF]) |->
        serial_out_pair_first == {$past(tx_sel), !$past(tx_sel)} &&
        serial_out_pair_second == {$past(rts_sel), !$past(rts_sel)})
        else $error("serial diff");
    chk_mono_a: assert property (pix_valid[0] && fmt == FMT_MONO |->
        pix_word[0].field0 == pix_word[0].raw[35:20]) else $error("mono map");
    chk_rgb_place: assert property (pix_valid[0] && fmt == FMT_RGB |->
        pix_word[0].field0[11:0] == pix_word[0].raw[35:24] &&
        pix_word[0].field1[11:0] == pix_word[0].raw[23:12] &&
        pix_word[0].field2[11:0] == pix_word[0].raw[11:0]) else $error("rgb map");
    chk_tap_narrow: assert property (pix_valid[0] && fmt == FMT_TAP8 |->
        pix_word[0].field0[7:0] == pix_word[0].raw[35:28] &&
        pix_word[0].field1[7:0] == pix_word[0].raw[27:20]) else $error("tap8 map");
    chk_tap_wide: assert property (pix_valid[0] && fmt == FMT_TAPW |->
        pix_word[0].field0 == pix_word[0].raw[35:20] &&
        pix_word[0].field1 == pix_word[0].raw[19:4]) else $error("tapw map");
    chk_chan_b: assert property (pix_valid[1] |->
        pix_word[1].field0 == pix_word[1].raw[19:4]) else $error("chan b map");
    chk_word_held: assert property (pix_valid[0] && !pix_ready[0] |=>
        pix_valid[0] && $stable(pix_word[0])) else $error("word lost");
    chk_aux_sync: assert property ($past(nrst) && $past(nrst, 2) |->
        aux_level == $past(aux_in, 2)) else $error("aux level");
endmodule : camera_input_bit_mapper_chk

bind camera_input_bit_mapper camera_input_bit_mapper_chk camera_input_bit_mapper_chk_inst (.*);

// [verif/tb.sv]
// Self-checking bench for the camera input bit mapper.
// Assumes cam_model on the camera pins and the checker bound from its own file.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import cam_map_pkg::*;
    logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic out_a1, out_a2, out_b1, out_b2;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cam_data;
    logic [35:0] w [3];
    cam_ctrl_type ctrl_a, ctrl_b;
    pix_word_type [1:0] pix_word;
    pix_word_type p;
    logic [1:0] pix_valid, pix_ready, si1, si2, so1, so2, tx, rts, rx, cts, trg;
    logic [3:0] aux_in, aux_level, cnt;
    logic [15:0] gpio_in, gpio_out, gpio_oe_n;
    int n_errors, comparisons, cyc, n;

    camera_input_bit_mapper camera_input_bit_mapper_inst (.clk_sys, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cam_data, .ctrl_a, .ctrl_b,
        .pix_word, .pix_valid, .pix_ready, .cam_ctrl_out_a_first(out_a1),
        .cam_ctrl_out_a_second(out_a2), .cam_ctrl_out_b_first(out_b1),
        .cam_ctrl_out_b_second(out_b2), .serial_in_pair_first(si1),
        .serial_in_pair_second(si2), .serial_out_pair_first(so1), .serial_out_pair_second(so2),
        .uart_tx(tx), .uart_rts(rts), .uart_rx(rx), .uart_cts(cts), .aux_in, .aux_level,
        .aux_trigger(trg), .gpio_in, .gpio_out, .gpio_oe_n);
    cam_model cam_model_inst (.cam_data, .ctrl_a, .ctrl_b);

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : tick

    // One APB transfer; read data and error land in rd and err.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask : rchk

    // Pops one word of a channel into p.
    task automatic take(input int ch);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pix_valid[ch] !== 1'b1 && n < 60);
        if (pix_valid[ch] !== 1'b1) n_errors++;
        p = pix_word[ch];
        pix_ready[ch] <= 1'b1;
        @(posedge clk_sys);
        pix_ready[ch] <= 1'b0;
    endtask : take

    task automatic ser(input logic [31:0] c, input logic [7:0] e);
        apb(1'b1, OFF_CTRL, c);
        tick(6);
        `CHK({rx, cts, so1, so2}, e)
    endtask : ser

    // Counts trigger pulses after a rising aux bit.
    task automatic trig(input int i, input logic en, input logic [3:0] e);
        aux_in <= 4'h0;
        apb(1'b1, OFF_CTRL, 32'(en) << (CTRL_TRIG_A + i));
        tick(4);
        aux_in[2 * i] <= 1'b1;
        cnt = 4'h0;
        repeat (8) begin
            @(posedge clk_sys);
            cnt += 4'(trg[i]);
        end
        `CHK(cnt, e)
    endtask : trig

    initial begin
        {clk_sys, nrst, psel, penable, pwrite} = 5'b0;
        {paddr, pwdata, pix_ready, aux_in, gpio_in} = '0;
        {si1, si2, tx, rts} = 8'b10_01_01_01;
        w = '{36'h9_6A5C_3E1D, 36'h1_2345_6789, 36'hE_DCBA_9876};
        tick(10);
        nrst <= 1'b1;
        rchk(OFF_CTRL, RDATA_RST);
        rchk(OFF_EXPO, RDATA_RST);
        `CHK(gpio_oe_n, 16'hFFFF)
        apb(1'b1, OFF_CTRL, 32'h0000_0008);
        tick(2);
        `CHK(gpio_oe_n, 16'hFF00)
        apb(1'b1, OFF_CTRL, 32'h0000_0010);
        tick(2);
        `CHK(gpio_oe_n, 16'h00FF)
        apb(1'b1, OFF_GPIO_OUT, 32'h0000_A55A);
        tick(2);
        `CHK(gpio_out, 16'hA55A)
        gpio_in <= 16'h3CC3;
        tick(4);
        apb(1'b1, OFF_GPIO_IN, 32'h0000_0000);
        rchk(OFF_GPIO_IN, 32'h0000_3CC3);
        apb(1'b1, 12'h018, 32'hFFFF_FFFF);
        `CHK(err, 1'b1)
        rchk(12'h018, 32'h0000_0000);
        $display("test gpio and map done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFF_EXPO, 32'(1) << i);
            tick(2);
            `CHK({out_b2, out_a2, out_b1, out_a1}, 4'(1 << i))
        end
        ser(32'h0000_0000, 8'h6C);
        ser(32'h0000_0020, 8'hEA);
        ser(32'h0000_0060, 8'hD5);
        aux_in <= 4'h6;
        tick(4);
        `CHK(aux_level, 4'h6)
        rchk(OFF_AUX, 32'h0000_0006);
        for (int i = 0; i < 2; i++) begin
            trig(i, 1'b1, 4'h1);
            trig(i, 1'b0, 4'h0);
        end
        $display("test outputs done");
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, OFF_CTRL, 32'(f << CTRL_FMT_LO) | 32'(f == 1));
            cam_model_inst.pixel(w[0], f == 1);
            take(0);
            case (f)
                0: `CHK({p.frame_enable, p.field0}, {1'b1, w[0][35:20]})
                1: `CHK({p.raw, p.field0, p.field2}, {w[0], 4'h0, w[0][35:24], 4'h0, w[0][11:0]})
                2: `CHK({p.field0[7:0], p.field1[7:0]}, w[0][35:20])
                default: `CHK({p.field0, p.field1}, w[0][35:4])
            endcase
            if (f != 1) begin
                take(1);
                `CHK(p.field0, w[0][19:4])
            end
        end
        $display("test formats done");
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        for (int i = 0; i < 3; i++) cam_model_inst.pixel(w[i], 1'b0);
        rchk(OFF_STATUS, 32'h0000_000F);
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 2; i++) begin
                take(c);
                `CHK(p.field0, c ? w[i][19:4] : w[i][35:20])
            end
        end
        tick(2);
        `CHK(pix_valid, 2'b00)
        apb(1'b1, OFF_STATUS, 32'h0000_000C);
        rchk(OFF_STATUS, 32'h0000_0000);
        $display("test buffer done");
        summarize();
    end
endmodule : tb
